//--- rtl/lock_cmd_pkg.sv
// Constants, opcodes and table lookups for the block lock command logic
// Summary of operation
// - Lock, unlock, gang and status commands act only in individual protect mode.
// - Opcode 36h sets the lock bit of the addressed 64 KB block or 4 KB sector.
// - Opcode 39h clears the lock bit of the addressed block or sector.
// - Single lock/unlock frame is opcode then exactly three address bytes.
// - Chip select rising off a byte boundary rejects the command, nothing changes.
// - Opcode 3Ch plus three address bytes returns lock status until select rises.
// - Returned status is 1 for a protected region, 0 for unprotected.
// - Lock status read answers only in individual protect mode.
// - Opcode 7Eh sets every lock bit, 98h clears all; no address bytes.
// - A lone opcode 30h frame clears program and erase fail flags.
// - Opcode 5Ah, three address bytes, one dummy, then table bytes from address.
// - Chip select rising ends a table read cleanly at any point.
// - Bytes 04h-06h return minor 00h, major 01h, header count 01h.
// - First header: ID 00h, revision 00h/01h, length 09h, pointer 30h.
// - Second header: vendor ID, revision 00h/01h, length 04h, pointer 60h.
// - After power-up every lock bit is 1.
// - In individual mode a low write protect pin protects everything.
// - Program or erase of a protected region sets its fail flag.
// - The individual protect select bit never returns to 0 once set; here reset clears it and reloads it from the stored bit.
package lock_cmd_pkg;

    localparam logic [7:0] OP_LOCK_ONE   = 8'h36;
    localparam logic [7:0] OP_UNLOCK_ONE = 8'h39;
    localparam logic [7:0] OP_RDLOCK     = 8'h3C;
    localparam logic [7:0] OP_LOCK_ALL   = 8'h7E;
    localparam logic [7:0] OP_UNLOCK_ALL = 8'h98;
    localparam logic [7:0] OP_CLRF       = 8'h30;
    localparam logic [7:0] OP_DISC       = 8'h5A;

    // Byte counts of a frame, opcode included
    localparam logic [2:0] NB_OPCODE = 3'h1;
    localparam logic [2:0] NB_ADDR   = 3'h4;
    localparam logic [2:0] NB_DUMMY  = 3'h5;
    localparam logic [2:0] NB_SAT    = 3'h7;

    localparam int         SECT      = 16;
    localparam logic [7:0] FILL      = 8'hFF;

    // Lock bit order: bottom sectors, middle blocks, top sectors
    function automatic logic [8:0] lock_index(input logic [23:0] a, input int nblk);
        logic [7:0] blk;
        blk = a[23:16] & 8'(nblk - 1);
        if (blk == 8'h00)
            return {5'h00, a[15:12]};
        else if (blk == 8'(nblk - 1))
            return 9'(SECT + nblk - 2) + {5'h00, a[15:12]};
        else
            return 9'(SECT - 1) + {1'b0, blk};
    endfunction

    // Header area only; the parameter table bodies are not held here
    function automatic logic [7:0] disc_byte(input logic [23:0] a, input logic [7:0] vid);
        if (a[23:5] != 19'h0_0000)
            return FILL;
        case (a[4:0])
            5'h00: return 8'h53;
            5'h01: return 8'h46;
            5'h02: return 8'h44;
            5'h03: return 8'h50;
            5'h04, 5'h08, 5'h09, 5'h11: return 8'h00;
            5'h05, 5'h06, 5'h0A, 5'h12: return 8'h01;
            5'h0B: return 8'h09;
            5'h0C: return 8'h30;
            5'h10: return vid;
            5'h13: return 8'h04;
            5'h14: return 8'h60;
            5'h0D, 5'h0E, 5'h15, 5'h16: return 8'h00;
            default: return FILL;
        endcase
    endfunction

endpackage

//--- rtl/bit_sync.sv
// Two flip-flop synchroniser for slow levels
`timescale 1ns/10ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_t;

    sync_t s;
    sync_t next_s;

    always_comb begin
        next_s.s1 = d;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            s <= '0;
        else
            s <= next_s;
    end

    assign q = s.s2;
endmodule

//--- rtl/lock_link.sv
// Serial shifter on the link clock: capture of opcode and address, reply drive
`timescale 1ns/10ps
module lock_link #(
    parameter int         NUM_BLOCKS = 256,
    parameter int         LOCK_BITS  = NUM_BLOCKS - 2 + 2 * lock_cmd_pkg::SECT,
    parameter logic [7:0] VENDOR_ID  = 8'hA7 // Arbitrary value
) (
    input  wire logic                 sclk,
    input  wire logic                 rst_b,
    input  wire logic                 cs_n,
    input  wire logic                 si,
    input  wire logic [LOCK_BITS-1:0] lock_view,
    input  wire logic                 mode,
    output logic                      so,
    output logic                      so_oe,
    output logic      [7:0]           opcode,
    output logic      [23:0]          addr,
    output logic      [2:0]           nbytes,
    output logic                      aligned,
    output logic                      edge_tgl
);
    typedef struct packed {
        logic [2:0]  bi;
        logic [2:0]  nb;
        logic [7:0]  sh;
        logic [7:0]  op;
        logic [23:0] addr;
        logic [23:0] ptr;
        logic [7:0]  tx;
        logic        talk;
        logic        aligned;
        logic        tgl;
    } link_t;

    link_t s;
    link_t next_s;
    logic  fresh;
    logic  so_q;

    // ****************************************
    // Frame start marker
    // ****************************************
    // Set while select is high; the clock may stand still between frames
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n)
            fresh <= 1'b1;
        else
            fresh <= 1'b0;
    end

    // ****************************************
    // Shift and decode
    // ****************************************
    always_comb begin
        logic [2:0]  bi;
        logic [2:0]  nb;
        logic [7:0]  cur_op;
        logic [23:0] cur_addr;
        logic [23:0] ptr;
        bi       = fresh ? 3'h0 : s.bi;
        nb       = fresh ? 3'h0 : s.nb;
        cur_op   = s.op;
        cur_addr = s.addr;
        ptr      = s.ptr;
        next_s         = s;
        next_s.sh      = {s.sh[6:0], si};
        next_s.bi      = bi + 3'h1;
        next_s.aligned = (bi == 3'h7);
        next_s.nb      = nb;
        if (fresh) begin
            next_s.tgl  = ~s.tgl;
            next_s.talk = 1'b0;
        end
        if (bi == 3'h7) begin
            cur_op   = (nb == 3'h0) ? next_s.sh : s.op;
            cur_addr = (nb != 3'h0 && nb < lock_cmd_pkg::NB_ADDR) ?
                       {s.addr[15:0], next_s.sh} : s.addr;
            next_s.op   = cur_op;
            next_s.addr = cur_addr;
            next_s.nb   = (nb == lock_cmd_pkg::NB_SAT) ? nb : nb + 3'h1;
            if (cur_op == lock_cmd_pkg::OP_RDLOCK && nb >= 3'h3 && mode) begin
                // Repeated every byte until select rises
                next_s.talk = 1'b1;
                next_s.tx   = {7'h00,
                    lock_view[lock_cmd_pkg::lock_index(cur_addr, NUM_BLOCKS)]};
            end else if (cur_op == lock_cmd_pkg::OP_DISC && nb >= 3'h4) begin
                ptr         = (nb == 3'h4) ? s.addr : s.ptr;
                next_s.talk = 1'b1;
                next_s.tx   = lock_cmd_pkg::disc_byte(ptr, VENDOR_ID);
                next_s.ptr  = ptr + 24'h00_0001;
            end
        end
    end

    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b)
            s <= '0;
        else
            s <= next_s;
    end

    // Reply changes on the falling edge so the host samples a settled bit
    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b)
            so_q <= 1'b0;
        else
            so_q <= s.tx[3'h7 - s.bi];
    end

    assign so       = so_q;
    assign so_oe    = ~cs_n & s.talk & ~fresh;
    assign opcode   = s.op;
    assign addr     = s.addr;
    assign nbytes   = s.nb;
    assign aligned  = s.aligned;
    assign edge_tgl = s.tgl;

    a_table_start: assert property (
        @(posedge sclk) disable iff (!rst_b)
        (!fresh && s.bi == 3'h7 && s.nb == 3'h4 && s.op == lock_cmd_pkg::OP_DISC)
        |=> s.talk && s.tx == lock_cmd_pkg::disc_byte($past(s.addr), VENDOR_ID))
        else $error("table read did not start at the given address");
endmodule

//--- rtl/flash_lock_ctrl.sv
// Block lock, gang lock, fail flag and discovery table command logic
`timescale 1ns/10ps
module flash_lock_ctrl #(
    parameter int         NUM_BLOCKS = 256,
    parameter logic [7:0] VENDOR_ID  = 8'hA7 // Arbitrary value
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        si,
    output logic             so,
    output logic             so_oe,
    input  wire logic        wp_n,
    input  wire logic        wel,
    input  wire logic        select_protect,
    input  wire logic        protect_select_stored,
    input  wire logic        prog_attempt,
    input  wire logic        erase_attempt,
    input  wire logic [23:0] attempt_addr,
    output logic             region_protected,
    output logic             program_fail,
    output logic             erase_fail,
    output logic             individual_protect_select
);
    localparam int LOCK_BITS = NUM_BLOCKS - 2 + 2 * lock_cmd_pkg::SECT;

    // ****************************************
    // Parameter check
    // ****************************************
    if (NUM_BLOCKS < 4 || NUM_BLOCKS > 256 || (NUM_BLOCKS & (NUM_BLOCKS - 1)) != 0) begin : g_bad
        $error("NUM_BLOCKS must be a power of two from 4 to 256");
    end

    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_FRAME = 1'b1
    } frame_st_t;

    typedef struct packed {
        frame_st_t            st;
        logic                 strap_done;
        logic                 mode;
        logic                 tgl_end;
        logic [LOCK_BITS-1:0] lock;
        logic                 pfail;
        logic                 efail;
        logic                 prot_q;
    } ctrl_t;

    ctrl_t s;
    ctrl_t next_s;

    logic                 cs_s;
    logic                 wp_s;
    logic                 tgl_s;
    logic [7:0]           l_op;
    logic [23:0]          l_addr;
    logic [2:0]           l_nb;
    logic                 l_aligned;
    logic                 l_tgl;
    logic [LOCK_BITS-1:0] lock_view;
    logic                 rise;
    logic                 valid;
    logic                 wr_ok;
    logic                 do_lock_one;
    logic                 do_unlock_one;
    logic                 do_lock_all;
    logic                 do_unlock_all;
    logic                 do_clr;
    logic [8:0]           cmd_idx;
    logic                 att_prot;

    // ****************************************
    // Link side
    // ****************************************
    lock_link #(
        .NUM_BLOCKS (NUM_BLOCKS),
        .LOCK_BITS  (LOCK_BITS),
        .VENDOR_ID  (VENDOR_ID)
    ) u_link (
        .sclk      (sclk),
        .rst_b     (rst_b),
        .cs_n      (cs_n),
        .si        (si),
        .lock_view (lock_view),
        .mode      (s.mode),
        .so        (so),
        .so_oe     (so_oe),
        .opcode    (l_op),
        .addr      (l_addr),
        .nbytes    (l_nb),
        .aligned   (l_aligned),
        .edge_tgl  (l_tgl)
    );

    // ****************************************
    // Crossings
    // ****************************************
    // Link words are only read after select is seen high, when the link clock is still
    bit_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk   (core_clk),
        .rst_b (rst_b),
        .d     ({cs_n, wp_n, l_tgl}),
        .q     ({cs_s, wp_s, tgl_s})
    );

    // Lock bits only change between frames, pin and mode terms at any time; the link reads the view directly
    assign lock_view = s.lock | {LOCK_BITS{s.mode & ~wp_s}};

    // ****************************************
    // Command decode
    // ****************************************
    always_comb begin
        rise = (s.st == ST_FRAME) && cs_s;
        // A frame with no clock edge leaves the toggle as it was
        valid    = rise && (tgl_s != s.tgl_end) && l_aligned;
        wr_ok    = valid && s.mode && wel;
        do_lock_one   = wr_ok && l_nb == lock_cmd_pkg::NB_ADDR
                        && l_op == lock_cmd_pkg::OP_LOCK_ONE;
        do_unlock_one = wr_ok && l_nb == lock_cmd_pkg::NB_ADDR
                        && l_op == lock_cmd_pkg::OP_UNLOCK_ONE;
        do_lock_all   = wr_ok && l_nb == lock_cmd_pkg::NB_OPCODE
                        && l_op == lock_cmd_pkg::OP_LOCK_ALL;
        do_unlock_all = wr_ok && l_nb == lock_cmd_pkg::NB_OPCODE
                        && l_op == lock_cmd_pkg::OP_UNLOCK_ALL;
        do_clr   = valid && l_nb == lock_cmd_pkg::NB_OPCODE
                   && l_op == lock_cmd_pkg::OP_CLRF;
        cmd_idx  = lock_cmd_pkg::lock_index(l_addr, NUM_BLOCKS);
        att_prot = lock_view[lock_cmd_pkg::lock_index(attempt_addr, NUM_BLOCKS)];
    end

    // ****************************************
    // State update
    // ****************************************
    always_comb begin
        next_s = s;
        // Stored select bit is taken once, in the first cycle after release
        if (!s.strap_done) begin
            next_s.strap_done = 1'b1;
            next_s.mode       = s.mode | protect_select_stored;
        end
        if (select_protect)
            next_s.mode = 1'b1;
        unique case (s.st)
            ST_IDLE: begin
                if (!cs_s)
                    next_s.st = ST_FRAME;
            end
            ST_FRAME: begin
                if (cs_s) begin
                    next_s.st      = ST_IDLE;
                    next_s.tgl_end = tgl_s;
                end
            end
        endcase
        if (do_lock_one)
            next_s.lock[cmd_idx] = 1'b1;
        if (do_unlock_one)
            next_s.lock[cmd_idx] = 1'b0;
        if (do_lock_all)
            next_s.lock = '1;
        if (do_unlock_all)
            next_s.lock = '0;
        if (do_clr) begin
            next_s.pfail = 1'b0;
            next_s.efail = 1'b0;
        end
        // Set after clear so a same-cycle failure is kept
        if (prog_attempt && att_prot)
            next_s.pfail = 1'b1;
        if (erase_attempt && att_prot)
            next_s.efail = 1'b1;
        next_s.prot_q = att_prot;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s      <= '0;
            s.lock <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign region_protected          = s.prot_q;
    assign program_fail              = s.pfail;
    assign erase_fail                = s.efail;
    assign individual_protect_select = s.mode;

    // ****************************************
    // Checks
    // ****************************************
    a_mode_sticky: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        individual_protect_select |=> individual_protect_select [*3])
        else $error("protect select bit fell back to zero");

    a_powerup_locked: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !s.strap_done |-> (&s.lock))
        else $error("lock bits not all set after reset");

    a_pfail_set: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (prog_attempt && att_prot) |=> program_fail)
        else $error("program fail flag missed a protected attempt");

    a_efail_set: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (erase_attempt && att_prot) |=> erase_fail)
        else $error("erase fail flag missed a protected attempt");

    a_flags_clear: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (rise && tgl_s != s.tgl_end && l_aligned && l_nb == 3'h1
         && l_op == lock_cmd_pkg::OP_CLRF && !prog_attempt && !erase_attempt)
        |=> !program_fail && !erase_fail)
        else $error("fail flags not cleared");

    a_no_mode_hold: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (rise && !individual_protect_select) |=> $stable(s.lock))
        else $error("lock bits changed outside individual mode");

    a_unaligned_hold: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (rise && !l_aligned) |=> $stable(s.lock))
        else $error("lock bits changed on an unaligned frame");

    a_no_wel_hold: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (rise && !wel) |=> $stable(s.lock))
        else $error("lock bits changed without write enable");

    a_single_lock: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (rise && tgl_s != s.tgl_end && l_aligned && individual_protect_select && wel
         && l_nb == 3'h4 && l_op == lock_cmd_pkg::OP_LOCK_ONE)
        |=> s.lock[$past(cmd_idx)])
        else $error("single lock did not set its bit");

    a_single_unlock: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (rise && tgl_s != s.tgl_end && l_aligned && individual_protect_select && wel
         && l_nb == 3'h4 && l_op == lock_cmd_pkg::OP_UNLOCK_ONE)
        |=> !s.lock[$past(cmd_idx)])
        else $error("single unlock did not clear its bit");

    a_gang_lock: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (rise && tgl_s != s.tgl_end && l_aligned && individual_protect_select && wel
         && l_nb == 3'h1 && l_op == lock_cmd_pkg::OP_LOCK_ALL)
        |=> (&s.lock))
        else $error("gang lock left a bit clear");

    a_gang_unlock: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (rise && tgl_s != s.tgl_end && l_aligned && individual_protect_select && wel
         && l_nb == 3'h1 && l_op == lock_cmd_pkg::OP_UNLOCK_ALL)
        |=> (s.lock == '0))
        else $error("gang unlock left a bit set");

    a_wp_protects: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (individual_protect_select && !wp_s) |=> region_protected)
        else $error("low write protect did not protect the region");

    a_frame_idle: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (cs_s && s.st == ST_IDLE) |=> (s.st == ST_IDLE))
        else $error("frame state left idle with select high");
endmodule

//--- tb/spi_host_model.sv
// Host serial controller model that frames commands into the lock block
`timescale 1ns/10ps
module spi_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe
);
    logic oe_seen;

    initial begin
        sclk    = 1'b0;
        cs_n    = 1'b1;
        si      = 1'b0;
        oe_seen = 1'b0;
    end

    // ************************************************
    // Frame driver
    // ************************************************
    // Clock stands low between frames; idle data toggles so no stale level lingers
    task automatic xfer(input logic [63:0] bits, input int nbits, input int nrd,
                        output logic [63:0] rd);
        rd      = 64'h0;
        oe_seen = 1'b0;
        cs_n    = 1'b0;
        for (int i = 0; i < nbits + 8 * nrd; i++) begin
            si = (i < nbits) ? bits[63 - i] : ~si;
            #7.5 sclk = 1'b1;
            if (i >= nbits) begin
                // Released line reads inverted, so a missing enable shows
                rd      = {rd[62:0], so_oe ? so : ~so};
                oe_seen = oe_seen | so_oe;
            end
            #7.5 sclk = 1'b0;
        end
        #7.5 cs_n = 1'b1;
        si = ~si;
        // Select high well beyond four core cycles so the end is seen
        #400;
    endtask
endmodule

//--- tb/block_lock_and_discovery_cmds_test.sv
// Self-checking bench for the block lock and discovery command logic
`timescale 1ns/10ps
module block_lock_and_discovery_cmds_test;
    localparam logic [7:0] VID = 8'h5E; // Arbitrary value
    logic core_clk, rst_b, sclk, cs_n, si, so, so_oe, wp_n, wel;
    logic select_protect, protect_select_stored, prog_attempt, erase_attempt;
    logic [23:0] attempt_addr;
    logic region_protected, program_fail, erase_fail, individual_protect_select;
    logic [63:0] rd;
    int num_errors = 0;
    int checks     = 0;

    flash_lock_ctrl #(.NUM_BLOCKS(256), .VENDOR_ID(VID)) dut (
        .core_clk(core_clk), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n), .si(si),
        .so(so), .so_oe(so_oe), .wp_n(wp_n), .wel(wel), .select_protect(select_protect),
        .protect_select_stored(protect_select_stored), .prog_attempt(prog_attempt),
        .erase_attempt(erase_attempt), .attempt_addr(attempt_addr),
        .region_protected(region_protected), .program_fail(program_fail),
        .erase_fail(erase_fail), .individual_protect_select(individual_protect_select));

    spi_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ************************************************
    // Helpers
    // ************************************************
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic strobe(ref logic s);
        @(negedge core_clk);
        s = 1'b1;
        @(negedge core_clk);
        s = 1'b0;
        cyc(2);
    endtask

    // Opcode, nb address bytes, then extra stray bits to break alignment
    task automatic send(input logic [7:0] op, input logic [23:0] a, input int nb, input int extra);
        host.xfer({op, a, 32'h0}, 8 + 8 * nb + extra, 0, rd);
        cyc(1);
    endtask

    task automatic status(input logic [23:0] a, input logic b);
        host.xfer({lock_cmd_pkg::OP_RDLOCK, a, 32'h0}, 32, 1, rd);
        check("lock status", rd, {56'h0, 7'h0, b});
        cyc(1);
    endtask

    initial begin
        #1_000_000;
        num_errors++;
        final_report();
    end

    // ************************************************
    // Tests
    // ************************************************
    initial begin
        logic [23:0] da [4];
        int          dn [4];
        logic [63:0] dx [4];
        da = '{24'h00_000E, 24'h00_0000, 24'h00_0008, 24'h00_0010};
        dn = '{2, 8, 8, 8};
        dx = '{64'h0000_0000_0000_00FF, 64'h5346_4450_0001_01FF,
               64'h0000_0109_3000_00FF, {VID, 56'h00_0104_6000_00FF}};
        rst_b = 1'b0;
        wp_n = 1'b1;
        wel = 1'b0;
        select_protect = 1'b0;
        protect_select_stored = 1'b0;
        prog_attempt = 1'b0;
        erase_attempt = 1'b0;
        attempt_addr = 24'h05_0000;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        rst_b = 1'b1;
        cyc(4);
        check("mode after reset", individual_protect_select, 64'h0);
        wel = 1'b1;
        send(lock_cmd_pkg::OP_UNLOCK_ALL, 24'h0, 0, 0);
        host.xfer({lock_cmd_pkg::OP_RDLOCK, 24'h05_0000, 32'h0}, 32, 1, rd);
        check("reply enable in mode 0", host.oe_seen, 64'h0);
        strobe(select_protect);
        check("mode set", individual_protect_select, 64'h1);
        status(24'h05_0000, 1'b1);
        $display("test mode done");
        wel = 1'b0;
        send(lock_cmd_pkg::OP_UNLOCK_ALL, 24'h0, 0, 0);
        status(24'h05_0000, 1'b1);
        wel = 1'b1; // Write enable latch held before each lock command
        send(lock_cmd_pkg::OP_UNLOCK_ALL, 24'h0, 0, 0);
        status(24'h05_0000, 1'b0);
        send(lock_cmd_pkg::OP_LOCK_ONE, 24'h05_0000, 3, 3);
        status(24'h05_0000, 1'b0);
        send(lock_cmd_pkg::OP_LOCK_ONE, 24'h05_0000, 2, 0);
        status(24'h05_0000, 1'b0);
        send(lock_cmd_pkg::OP_LOCK_ONE, 24'h05_0000, 3, 0);
        status(24'h05_0000, 1'b1);
        status(24'h06_0000, 1'b0);
        send(lock_cmd_pkg::OP_LOCK_ONE, 24'h00_3000, 3, 0);
        status(24'h00_3000, 1'b1);
        status(24'h00_4000, 1'b0);
        send(lock_cmd_pkg::OP_UNLOCK_ONE, 24'h05_0000, 3, 0);
        status(24'h05_0000, 1'b0);
        $display("test single lock done");
        wp_n = 1'b0;
        cyc(6);
        check("protect with pin low", region_protected, 64'h1);
        status(24'h05_0000, 1'b1);
        wp_n = 1'b1;
        cyc(6);
        check("protect with pin high", region_protected, 64'h0);
        strobe(prog_attempt);
        check("program fail open", program_fail, 64'h0);
        attempt_addr = 24'h00_3000;
        strobe(prog_attempt);
        strobe(erase_attempt);
        check("program fail", program_fail, 64'h1);
        check("erase fail", erase_fail, 64'h1);
        send(lock_cmd_pkg::OP_CLRF, 24'h0, 0, 5);
        check("fails after bad clear", {program_fail, erase_fail}, 64'h3);
        send(lock_cmd_pkg::OP_CLRF, 24'h0, 0, 0);
        check("fails after clear", {program_fail, erase_fail}, 64'h0);
        send(lock_cmd_pkg::OP_LOCK_ALL, 24'h0, 0, 0);
        status(24'h80_0000, 1'b1);
        status(24'hFF_F000, 1'b1);
        $display("test protect and flags done");
        // Second reset with the stored select bit set; lock bits must come back set
        send(lock_cmd_pkg::OP_UNLOCK_ALL, 24'h0, 0, 0);
        protect_select_stored = 1'b1;
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        cyc(4);
        check("mode from stored bit", individual_protect_select, 64'h1);
        status(24'h05_0000, 1'b1);
        $display("test reset done");
        // First read is cut short mid-output; the rest must still start cleanly
        host.xfer({lock_cmd_pkg::OP_DISC, 24'h00_0000, 8'h00, 24'h0}, 44, 0, rd);
        for (int i = 0; i < 4; i++) begin
            host.xfer({lock_cmd_pkg::OP_DISC, da[i], 8'h00, 24'h0}, 40, dn[i], rd);
            check("table bytes", rd, dx[i]);
        end
        $display("test discovery table done");
        final_report();
    end
endmodule
